// *** src/lic_led_control.v ***
// LED indicator control: event stretching, output disable and lowest-speed LED select.
`timescale 1ns/1ns
`default_nettype none
`include "lic_defs.vh"
module lic_led_control #(
  parameter integer MS_CYCLES = `LIC_CLK_KHZ,
  parameter integer BLINK_HALF_MS = 256
) (
  input wire clk,
  input wire resetn,
  input wire clk_en,
  input wire led_config_strap_pin,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire tx_activity,
  input wire rx_activity,
  input wire collision,
  input wire link_up,
  input wire speed_1000,
  input wire speed_100,
  input wire speed_10,
  output reg lowest_speed_indicator
);

  // Register slots after address decode.
  localparam [1:0] SLOT_NONE = 2'b00;
  localparam [1:0] SLOT_CTRL1 = 2'b01;
  localparam [1:0] SLOT_SEL = 2'b10;
  localparam [1:0] SLOT_EXTDUR = 2'b11;

  // Stretch channels: zero is transmit or receive activity, one is collision.
  localparam integer NCH = 2;

  reg [15:0] ctrl1_q;
  reg [3:0] sel_q;
  reg [8:0] extdur_q;
  reg init_q;
  reg [14:0] ms_q;
  reg ms_tick;
  reg [8:0] blink_q;
  reg blink_on_q;
  reg [10:0] dur_ms;
  reg func;

  function [1:0] slot_of;
    input [7:0] addr;
    begin
      case (addr)
        `LIC_OFS_CTRL1: slot_of = SLOT_CTRL1;
        `LIC_OFS_SEL: slot_of = SLOT_SEL;
        `LIC_OFS_EXTDUR: slot_of = SLOT_EXTDUR;
        default: slot_of = SLOT_NONE;
      endcase
    end
  endfunction

  wire wr_ctrl1 = reg_wr & (slot_of(reg_addr) == SLOT_CTRL1);
  wire wr_sel = reg_wr & (slot_of(reg_addr) == SLOT_SEL);
  wire wr_extdur = reg_wr & (slot_of(reg_addr) == SLOT_EXTDUR);
  wire stretch_en = ctrl1_q[`LIC_BIT_STRETCH_EN];
  wire out_dis = ctrl1_q[`LIC_BIT_OUT_DIS];
  wire ext_low = ctrl1_q[`LIC_POS_EXT_LOW];
  wire [1:0] dur_code = ctrl1_q[`LIC_POS_DUR+1:`LIC_POS_DUR];
  wire ms_last = (ms_q == MS_CYCLES - 1);
  wire blink_last = (blink_q == BLINK_HALF_MS - 1);
  wire [NCH-1:0] ev_in = {collision, tx_activity | rx_activity};
  wire [NCH-1:0] ev_led;
  wire act_led = ev_led[0];
  wire col_led = ev_led[1];

  // Eleven bits, since the longest extended length of 2 s is 2000 ms.
  always @*
  begin
    case (dur_code)
      2'b00: dur_ms = `LIC_DUR0_MS;
      2'b01: dur_ms = `LIC_DUR1_MS;
      2'b10: dur_ms = `LIC_DUR2_MS;
      default: dur_ms = {extdur_q, 2'b00};
    endcase
  end

  // Extended mode is one of the many extended codes; only the low-speed meaning is kept here.
  always @*
  begin
    func = 1'b0;
    if (ext_low)
      func = (sel_q == `LIC_XSEL_LOWSPD) & (speed_10 | speed_100) & link_up;
    else
    begin
      case (sel_q)
        `LIC_SEL_GIG: func = speed_1000 & link_up;
        `LIC_SEL_LINK: func = link_up;
        `LIC_SEL_ACT: func = act_led;
        `LIC_SEL_COL: func = col_led;
        `LIC_SEL_BLINK: func = blink_on_q;
        `LIC_SEL_ON: func = 1'b1;
        `LIC_SEL_OFF: func = 1'b0;
        default: func = 1'b0;
      endcase
    end
  end

  // The strap is caught on the first enabled edge after reset release, never by the async reset.
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl1_q <= `LIC_CTRL1_RST;
      sel_q <= `LIC_SEL_RST_STRAP0;
      extdur_q <= 9'h000;
      init_q <= 1'b1;
    end
    else if (clk_en)
    begin
      init_q <= 1'b0;
      if (init_q)
      begin
        ctrl1_q[`LIC_BIT_OUT_DIS] <= led_config_strap_pin;
        ctrl1_q[`LIC_POS_EXT_LOW] <= led_config_strap_pin;
        sel_q <= led_config_strap_pin ? `LIC_SEL_RST_STRAP1 : `LIC_SEL_RST_STRAP0;
      end
      else
      begin
        if (wr_ctrl1)
          ctrl1_q <= {reg_wdata[15:10], 6'h00, reg_wdata[3:0]};
        if (wr_sel)
          sel_q <= reg_wdata[15:12];
        if (wr_extdur)
          extdur_q <= (reg_wdata[8:0] > `LIC_EXT_MAX) ? `LIC_EXT_MAX : reg_wdata[8:0];
      end
    end
  end

  // Read data stand for one enabled cycle only, so a stale word is never taken twice.
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 16'h0000;
    else if (clk_en)
    begin
      if (!reg_rd)
        reg_rdata <= 16'h0000;
      else
      begin
        case (slot_of(reg_addr))
          SLOT_CTRL1: reg_rdata <= ctrl1_q;
          SLOT_SEL: reg_rdata <= {sel_q, 12'h000};
          SLOT_EXTDUR: reg_rdata <= {7'h00, extdur_q};
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ms_q <= 15'h0000;
      ms_tick <= 1'b0;
    end
    else if (clk_en)
    begin
      ms_tick <= ms_last;
      if (ms_last)
        ms_q <= 15'h0000;
      else
        ms_q <= ms_q + 15'h0001;
    end
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      blink_q <= 9'h000;
      blink_on_q <= 1'b0;
    end
    else if (clk_en && ms_tick)
    begin
      if (blink_last)
      begin
        blink_q <= 9'h000;
        blink_on_q <= ~blink_on_q;
      end
      else
        blink_q <= blink_q + 9'h001;
    end
  end

  // The timer runs even with stretching off, so enabling it later shows no stale length.
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1)
    begin : g_stretch
      reg [10:0] left_q;

      always @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          left_q <= 11'h000;
        else if (clk_en)
        begin
          if (ev_in[ch])
            left_q <= dur_ms;
          else if (ms_tick && left_q != 11'h000)
            left_q <= left_q - 11'h001;
        end
      end

      assign ev_led[ch] = stretch_en ? (ev_in[ch] | (left_q != 11'h000)) : ev_in[ch];
    end
  endgenerate

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      lowest_speed_indicator <= 1'b0;
    else if (clk_en)
      lowest_speed_indicator <= func & ~out_dis;
  end
endmodule // lic_led_control
`default_nettype wire

// *** pkg/lic_defs.vh ***
// Constants of the LED indicator control block.
//
// Contract
// - Duration codes 00b, 01b and 10b stretch events 32, 64 and 104 ms.
// - Code 11b uses an extended length of 0 to 2 s in 4 ms steps.
// - While the output disable bit is one, all LED outputs stay inactive.
// - The output disable bit resets to the level of the config strap.
// - Stretch enable resets to one; when set, activity and collision get stretched.
// - Bits 15:12 of the second register select the lowest-speed LED function.
// - Standard codes: gigabit, link, activity, collision, blink, on, off.
// - A per-LED extended-mode bit chooses standard or extended code meaning.
`ifndef LIC_DEFS_VH
`define LIC_DEFS_VH
`define LIC_OFS_CTRL1 8'h1b
`define LIC_OFS_SEL 8'h1c
`define LIC_OFS_EXTDUR 8'h1d
`define LIC_BIT_STRETCH_EN 0
`define LIC_BIT_OUT_DIS 1
`define LIC_POS_DUR 2
`define LIC_POS_EXT_LOW 13
`define LIC_POS_SEL_LOW 12
`define LIC_CTRL1_RST 16'h0001
`define LIC_SEL_RST_STRAP1 4'hf
`define LIC_SEL_RST_STRAP0 4'h2
`define LIC_DUR0_MS 11'd32
`define LIC_DUR1_MS 11'd64
`define LIC_DUR2_MS 11'd104
`define LIC_STEP_MS 4
`define LIC_EXT_MAX 9'd500
`define LIC_CLK_KHZ 25000
`define LIC_SEL_GIG 4'h0
`define LIC_SEL_LINK 4'h4
`define LIC_SEL_ACT 4'h7
`define LIC_SEL_COL 4'h9
`define LIC_SEL_BLINK 4'hd
`define LIC_SEL_ON 4'he
`define LIC_SEL_OFF 4'hf
`define LIC_XSEL_LOWSPD 4'h0
`endif

// *** sim/lic_led_checker.sv ***
// Checker for the register port and LED output of the LED indicator control.
`timescale 1ns/1ns
`default_nettype none
module lic_led_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic lowest_speed_indicator
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_idle;
    !$past(reg_rd) |-> reg_rdata == 16'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("read data out of slot");
  property p_unmap;
    reg_rd && reg_addr > 8'h1d |=> reg_rdata == 16'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_dis;
    clk_en && reg_wr && reg_addr == 8'h1b && reg_wdata[1] ##1 clk_en |=> !lowest_speed_indicator;
  endproperty
  a_dis: assert property (p_dis) else $error("led lit while disabled");
  property p_ctrl_rd;
    clk_en && reg_wr && reg_addr == 8'h1b ##2 reg_rd && reg_addr == 8'h1b
      |=> reg_rdata == ($past(reg_wdata, 3) & 16'hfc0f);
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control word not kept");
  property p_sel_rd;
    clk_en && reg_wr && reg_addr == 8'h1c ##2 reg_rd && reg_addr == 8'h1c
      |=> reg_rdata == ($past(reg_wdata, 3) & 16'hf000);
  endproperty
  a_sel_rd: assert property (p_sel_rd) else $error("selector not kept");
  property p_clip;
    clk_en && reg_wr && reg_addr == 8'h1d && reg_wdata[8:0] > 9'd500 ##2 reg_rd && reg_addr == 8'h1d
      |=> reg_rdata == 16'h01f4;
  endproperty
  a_clip: assert property (p_clip) else $error("extended length not clipped");
  c_rd: cover property (reg_rd ##1 reg_rdata != 16'h0);
  c_un: cover property (reg_rd && reg_addr > 8'h1d);
  c_zero: cover property (reg_rd ##1 reg_rdata == 16'h0);
endmodule // lic_led_checker
`default_nettype wire

// *** sim/lic_led_model.sv ***
// Model of the indicator LED hanging on the output pin.
`timescale 1ns/1ns
`default_nettype none
module lic_led_model (
  input wire logic clk,
  input wire logic drive,
  output logic lit
);
  // The lamp is seen one cycle late, as an observer would.
  always @(posedge clk)
  begin
    lit <= drive;
  end
endmodule // lic_led_model
`default_nettype wire

// *** sim/lic_led_control_bench.sv ***
// Self-checking bench for the LED indicator control.
`timescale 1ns/1ns
`default_nettype none
`include "lic_defs.vh"
module lic_led_control_bench;
  logic clk = 0, resetn = 0, wr = 0, rd = 0, pend = 0, en = 1, strap, pin, lit;
  logic [2:0] ev = 0;
  logic [3:0] ls;
  logic [7:0] addr = 0;
  logic [15:0] wd = 0, rdata;
  logic [31:0] e, f, exq[$];
  int mismatches = 0, samples_checked = 0, seed = 32'hfc90, d[4] = '{32, 64, 104, 20};
  lic_led_control #(.MS_CYCLES(10), .BLINK_HALF_MS(2)) dut_u (.clk(clk), .resetn(resetn),
    .clk_en(en), .led_config_strap_pin(strap), .reg_addr(addr), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .tx_activity(ev[0]), .rx_activity(ev[1]),
    .collision(ev[2]), .link_up(ls[0]), .speed_1000(ls[1]), .speed_100(ls[2]),
    .speed_10(ls[3]), .lowest_speed_indicator(pin));
  lic_led_model led_u (.clk(clk), .drive(pin), .lit(lit));
  task automatic cmp(string n, logic [15:0] x, logic [15:0] s);
    samples_checked++;
    if (x !== s)
    begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, x, s);
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [15:0] v);
    addr <= a;
    wd <= v;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(logic [7:0] a, logic [15:0] m, logic [15:0] x);
    exq.push_back({m, x});
    bus(1'b0, a, 16'h0);
  endtask
  task automatic test_done;
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    forever #20 clk = ~clk;
  end
  initial
  begin
    #400000;
    mismatches++;
    test_done;
  end
  always @(posedge clk)
  begin
    if (pend)
    begin
      f = exq.pop_front();
      cmp("rdata", f[15:0], rdata & f[31:16]);
    end
    pend <= rd;
  end
  initial
  begin
    {strap, ls} = 5'($random(seed));
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    rreg(`LIC_OFS_CTRL1, 16'hffff, {2'b0, strap, 11'h0, strap, 1'b1});
    rreg(`LIC_OFS_SEL, 16'hf000, {strap ? 4'hf : 4'h2, 12'h0});
    rreg(8'h40, 16'hffff, 16'h0);
    e = $random(seed);
    bus(1'b1, `LIC_OFS_CTRL1, e[15:0]);
    rreg(`LIC_OFS_CTRL1, 16'hffff, e[15:0] & 16'hfc0f);
    bus(1'b1, `LIC_OFS_CTRL1, 16'h0001);
    bus(1'b1, `LIC_OFS_SEL, {`LIC_SEL_ON, 12'h0});
    rreg(`LIC_OFS_SEL, 16'hffff, {`LIC_SEL_ON, 12'h0});
    repeat (2) @(posedge clk);
    cmp("led", 16'h1, 16'(lit));
    en <= 1'b0;
    bus(1'b1, `LIC_OFS_CTRL1, 16'h0003);
    en <= 1'b1;
    repeat (2) @(posedge clk);
    cmp("led_frozen", 16'h1, 16'(lit));
    bus(1'b1, `LIC_OFS_CTRL1, 16'h0003);
    repeat (2) @(posedge clk);
    cmp("led", 16'h0, 16'(lit));
    bus(1'b1, `LIC_OFS_EXTDUR, 16'h01ff);
    rreg(`LIC_OFS_EXTDUR, 16'hffff, 16'h01f4);
    bus(1'b1, `LIC_OFS_EXTDUR, 16'h0005);
    bus(1'b1, `LIC_OFS_SEL, {`LIC_SEL_ACT, 12'h0});
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, `LIC_OFS_CTRL1, 16'(4 * i + 1));
      repeat (2)
      begin
        ev <= i[0] ? 3'b010 : 3'b001;
        @(posedge clk);
        ev <= 3'b0;
        repeat (6 * d[i]) @(posedge clk);
      end
      cmp("led", 16'h1, 16'(lit));
      repeat (4 * d[i] + 15) @(posedge clk);
      cmp("led", 16'h0, 16'(lit));
    end
    test_done;
  end
endmodule // lic_led_control_bench
bind lic_led_control lic_led_checker chk_u (.clk(clk), .resetn(resetn), .clk_en(clk_en),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .lowest_speed_indicator(lowest_speed_indicator));
`default_nettype wire
